// ### dv/aai_host_model.sv
// host-side model: watches the two interrupt pins and counts pulses on them.
// assumes pins are synchronous to core_clk and high while asserted.
`timescale 1ns/1ns
module aai_host_model
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic gpio_level,
    input  wire logic miso_level,
    output int        gpio_pulses,
    output int        miso_pulses
);
    // ==========================================================
    // pulse counting
    // ==========================================================
    logic gpio_last;    // gpio level at the previous edge
    logic miso_last;    // miso level at the previous edge

    // a pulse counts once, at its rise, so a two-cycle pulse is not counted twice
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            gpio_last   <= 1'b0;
            miso_last   <= 1'b0;
            gpio_pulses <= 0;
            miso_pulses <= 0;
        end
        else
        begin
            gpio_last <= gpio_level;
            miso_last <= miso_level;
            if (gpio_level === 1'b1 && gpio_last !== 1'b1)
                gpio_pulses <= gpio_pulses + 1;
            if (miso_level === 1'b1 && miso_last !== 1'b1)
                miso_pulses <= miso_pulses + 1;
        end
    end
endmodule : aai_host_model

// ### dv/aai_interrupt_logic_bench.sv
// self-checking bench for the amplifier interrupt block.
// assumes the host model counts pin pulses; ce drops once to check freezing.
`timescale 1ns/1ns
module aai_interrupt_logic_bench;
    import aai_pkg::*;
    // ==========================================================
    // signals
    // ==========================================================
    logic            core_clk, srst, ce, ev_hp_overcurrent;          // clock, reset, enable, overcurrent
    logic [OV_W-1:0] ev_overflow;                                    // overflow events
    logic [11:0]     s_axi_awaddr, s_axi_araddr;                     // bus addresses
    logic [31:0]     s_axi_wdata, s_axi_rdata;                       // bus data
    logic [3:0]      s_axi_wstrb;                                    // byte strobes
    logic [1:0]      s_axi_bresp, s_axi_rresp;                       // responses
    logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic            interrupt_out_one, interrupt_out_two, gpio_int_out, miso_int_out, miso_int_sel, irq;
    logic            dout_int_out;                                   // data-out pin
    int              gpio_pulses, miso_pulses;                       // pulses seen by the host
    int              n_mismatch = 0;                                 // mismatches
    int              check_count = 0;                                // comparisons
    int              c1, c2, c3, snap;                               // scenario scratch
    logic [31:0]     rd_data;                                        // scenario scratch
    logic [1:0]      rsp;                                            // scenario scratch

    aai_interrupt_logic aai_interrupt_logic_inst
    (
        .core_clk, .srst, .ce, .ev_hp_overcurrent, .ev_overflow,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .interrupt_out_one, .interrupt_out_two, .gpio_int_out, .dout_int_out, .miso_int_out,
        .miso_int_sel, .irq
    );

    aai_host_model aai_host_model_inst
    (
        .core_clk, .srst, .gpio_level(gpio_int_out), .miso_level(miso_int_out), .gpio_pulses, .miso_pulses
    );

    // ==========================================================
    // clock, verdict and watchdog
    // ==========================================================
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // the run needs well under a thousand cycles, so this only trips on a hang
    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : compare

    // both halves offered together, each released at the edge that takes it
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, input logic [1:0] want);
        bit aw_on;
        bit w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        rsp = 2'h3;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        for (int k = 0; k < 100; k++)
        begin
            @(posedge core_clk);
            if (aw_on && s_axi_awready === 1'b1)
            begin
                aw_on = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_on && s_axi_wready === 1'b1)
            begin
                w_on = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1)
            begin
                rsp = s_axi_bresp;
                break;
            end
        end
        compare("write response", 32'(rsp), 32'(want));
    endtask : axi_write

    // rready stays high, so the edge that shows rvalid also takes the data
    task automatic axi_read(input logic [11:0] addr, input logic [31:0] want, input logic [1:0] want_rsp);
        bit ar_on;
        ar_on = 1'b1;
        rsp = 2'h3;
        rd_data = 32'hFFFF_FFFF;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        for (int k = 0; k < 100; k++)
        begin
            @(posedge core_clk);
            if (ar_on && s_axi_arready === 1'b1)
            begin
                ar_on = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1)
            begin
                rd_data = s_axi_rdata;
                rsp = s_axi_rresp;
                break;
            end
        end
        compare("read response", 32'(rsp), 32'(want_rsp));
        compare("read data", rd_data, want);
    endtask : axi_read

    // counts the cycles each interrupt output and the data-out pin are high over a window
    task automatic watch(input int n);
        c1 = 0;
        c2 = 0;
        c3 = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            if (interrupt_out_one === 1'b1)
                c1++;
            if (interrupt_out_two === 1'b1)
                c2++;
            if (dout_int_out === 1'b1)
                c3++;
        end
    endtask : watch

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic test_reset_values();
        axi_read(12'h0C0, 32'h0000_0000, RESP_OKAY);
        axi_read(12'h0C4, 32'h0000_0000, RESP_OKAY);
        axi_read(12'h0D0, 32'h0000_0000, RESP_OKAY);
        axi_read(12'h3F0, 32'h0000_0000, RESP_SLVERR);
        axi_write(12'h3F0, 32'h0000_00FF, RESP_SLVERR);
    endtask : test_reset_values

    // one overcurrent pulse on output one, routed to the general pin
    task automatic test_single_pulse();
        axi_write(12'h0C0, 32'h0000_0080, RESP_OKAY);
        axi_write(12'h0D0, 32'h0000_0001, RESP_OKAY);
        ev_overflow <= 3'b010;
        @(posedge core_clk);
        ev_overflow <= 3'b000;
        watch(12);
        compare("out one on disabled event", 32'(c1), 0);
        ev_hp_overcurrent <= 1'b1;
        @(posedge core_clk);
        ev_hp_overcurrent <= 1'b0;
        watch(12);
        compare("single pulse width", 32'(c1), 32'(PULSE_CYC));
        compare("out two untouched", 32'(c2), 0);
        compare("gpio pulses", 32'(gpio_pulses), 1);
        axi_read(12'h0A8, 32'h0000_0001, RESP_OKAY);
        axi_read(12'h0A8, 32'h0000_0000, RESP_OKAY);
    endtask : test_single_pulse

    // overflow train on output two, routed to spi data-out, ended by a flag read
    task automatic test_train();
        axi_write(12'h0C4, 32'h0000_0011, RESP_OKAY);
        axi_write(12'h0DC, 32'h0000_0002, RESP_OKAY);
        axi_write(12'h0D4, 32'h0000_0002, RESP_OKAY);
        axi_read(12'h0C4, 32'h0000_0011, RESP_OKAY);
        compare("miso carries interrupt", 32'(miso_int_sel), 1);
        ev_overflow <= 3'b001;
        @(posedge core_clk);
        ev_overflow <= 3'b000;
        watch(4 * TRAIN_CYC);
        compare("train high cycles", 32'(c2), 32'(4 * PULSE_CYC));
        compare("dout train cycles", 32'(c3), 32'(4 * PULSE_CYC));
        compare("out one during train", 32'(c1), 0);
        compare("miso pulses", 32'(miso_pulses), 4);
        axi_read(12'h0B0, 32'h0000_0003, RESP_OKAY);
        watch(4);
        snap = miso_pulses;
        watch(3 * TRAIN_CYC);
        compare("train after read", 32'(c2), 0);
        compare("dout after read", 32'(c3), 0);
        compare("miso after read", 32'(miso_pulses), 32'(snap));
    endtask : test_train

    // both triggers left status bits; mask, raise and clear the level interrupt
    task automatic test_irq();
        axi_read(12'h100, 32'h0000_0003, RESP_OKAY);
        compare("irq masked", 32'(irq), 0);
        axi_write(12'h104, 32'h0000_0001, RESP_OKAY);
        watch(1);
        compare("irq unmasked", 32'(irq), 1);
        ce <= 1'b0;
        watch(2);
        compare("ready while frozen", 32'(s_axi_awready), 0);
        compare("irq while frozen", 32'(irq), 1);
        ce <= 1'b1;
        axi_write(12'h100, 32'h0000_0001, RESP_OKAY);
        watch(1);
        compare("irq cleared", 32'(irq), 0);
        axi_read(12'h100, 32'h0000_0002, RESP_OKAY);
    endtask : test_irq

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        ev_hp_overcurrent = 1'b0;
        ev_overflow = 3'b000;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        test_reset_values();
        test_single_pulse();
        test_train();
        test_irq();
        close_out();
    end
endmodule : aai_interrupt_logic_bench

// ### rtl/aai_interrupt_logic.sv
// interrupt logic of a mono speaker amplifier: event flags, two interrupt
// outputs, pin routing and an axi4-lite register slave.
// assumes event inputs come from logic on core_clk; the host clears pulse
// trains by reading the flag registers.
`timescale 1ns/1ns
module aai_interrupt_logic
(
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     ce,
    input  wire logic                     ev_hp_overcurrent,
    input  wire logic [aai_pkg::OV_W-1:0] ev_overflow,
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic                          interrupt_out_one,
    output logic                          interrupt_out_two,
    output logic                          gpio_int_out,
    output logic                          dout_int_out,
    output logic                          miso_int_out,
    output logic                          miso_int_sel,
    output logic                          irq
);
    import aai_pkg::*;

    // ==========================================================
    // storage
    // ==========================================================
    logic [7:0]       cfg [2];        // per output configuration
    logic [7:0]       rt_gpio;        // general pin routing
    logic [7:0]       rt_dout;        // data-out pin routing
    logic [7:0]       rt_miso;        // spi data-out routing
    logic             flag_oc;        // sticky overcurrent
    logic [OV_W-1:0]  flag_ov;        // sticky overflows
    logic             ev_oc_prev;     // for edge detection
    logic [OV_W-1:0]  ev_ov_prev;
    logic [1:0]       irq_status;     // bit c: output c triggered
    logic [1:0]       irq_mask;
    logic [CNT_W-1:0] pcnt [2];       // single pulse countdown
    logic [CNT_W-1:0] tcnt [2];       // train phase
    logic [1:0]       int_q;          // interrupt outputs
    logic             aw_held;        // write address captured
    logic             w_held;         // write data captured
    logic [11:0]      aw_addr_q;
    logic [7:0]       w_data_q;
    logic             w_lane0;        // low byte lane enabled

    // ==========================================================
    // address decode
    // ==========================================================
    // only aligned words in the low 1 KiB map to an index
    function automatic logic [8:0] aai_decode(input logic [11:0] a);
        logic [7:0] i;
        logic       ok;
        i  = a[9:2];
        ok = (a[11:10] == 2'h0) && (a[1:0] == 2'h0);
        if (ok && (i == IDX_FLAG_OC || i == IDX_FLAG_OV || i == IDX_CFG_ONE ||
                   i == IDX_CFG_TWO || i == IDX_RT_GPIO || i == IDX_RT_DOUT ||
                   i == IDX_RT_MISO || i == IDX_IRQ_STAT || i == IDX_IRQ_MASK))
            return {1'b1, i};
        return {1'b0, i};
    endfunction : aai_decode

    // pick the interrupt that a routing register names
    function automatic logic aai_route(input logic [7:0] r, input logic [1:0] iv);
        unique case (r[1:0])
            ROUTE_ONE: return iv[0];
            ROUTE_TWO: return iv[1];
            default:   return 1'b0;   // off or reserved code: pin stays low
        endcase
    endfunction : aai_route

    // ==========================================================
    // axi4-lite handshakes
    // ==========================================================
    logic [8:0] wr_dec;
    logic [8:0] rd_dec;
    logic       wr_go;
    logic       ar_fire;
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_go   = ce && aw_held && w_held && !s_axi_bvalid;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_dec  = aai_decode(aw_addr_q);
    assign rd_dec  = aai_decode(s_axi_araddr);

    logic rd_clr_oc;
    logic rd_clr_ov;
    assign rd_clr_oc = ar_fire && rd_dec[8] && rd_dec[7:0] == IDX_FLAG_OC;
    assign rd_clr_ov = ar_fire && rd_dec[8] && rd_dec[7:0] == IDX_FLAG_OV;

    logic wr_en;   // a mapped write with the low byte lane on
    assign wr_en = wr_go && wr_dec[8] && w_lane0;

    // write address and data are taken in either order
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 8'h00;
            w_lane0   <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane0  <= s_axi_wstrb[0];
            end
            else if (wr_go)
                w_held <= 1'b0;
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read data one cycle after the address; flag reads clear their flags
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
                unique case (rd_dec[7:0])
                    IDX_FLAG_OC:  s_axi_rdata <= {31'h0, flag_oc};
                    IDX_FLAG_OV:  s_axi_rdata <= {{(32-OV_W){1'b0}}, flag_ov};
                    IDX_CFG_ONE:  s_axi_rdata <= {24'h0, cfg[0]};
                    IDX_CFG_TWO:  s_axi_rdata <= {24'h0, cfg[1]};
                    IDX_RT_GPIO:  s_axi_rdata <= {24'h0, rt_gpio};
                    IDX_RT_DOUT:  s_axi_rdata <= {24'h0, rt_dout};
                    IDX_RT_MISO:  s_axi_rdata <= {24'h0, rt_miso};
                    IDX_IRQ_STAT: s_axi_rdata <= {30'h0, irq_status};
                    IDX_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                    default:      s_axi_rdata <= 32'h0000_0000;  // indices of no register read zero
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cfg[0]   <= CFG_RST;
            cfg[1]   <= CFG_RST;
            rt_gpio  <= ROUTE_RST;
            rt_dout  <= ROUTE_RST;
            rt_miso  <= ROUTE_RST;
            irq_mask <= 2'h0;
        end
        else if (ce && wr_en)
        begin
            unique case (wr_dec[7:0])
                IDX_CFG_ONE:  cfg[0]   <= w_data_q;
                IDX_CFG_TWO:  cfg[1]   <= w_data_q;
                IDX_RT_GPIO:  rt_gpio  <= w_data_q;
                IDX_RT_DOUT:  rt_dout  <= w_data_q;
                IDX_RT_MISO:  rt_miso  <= w_data_q;
                IDX_IRQ_MASK: irq_mask <= w_data_q[1:0];
                default:      ;                           // flags and status handled below
            endcase
        end
    end

    // ==========================================================
    // event flags
    // ==========================================================
    // a new event in the cycle of the clearing read wins, so nothing is lost
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flag_oc    <= 1'b0;
            flag_ov    <= '0;
            ev_oc_prev <= 1'b0;
            ev_ov_prev <= '0;
        end
        else if (ce)
        begin
            flag_oc    <= (flag_oc & ~rd_clr_oc) | ev_hp_overcurrent;
            flag_ov    <= (flag_ov & {OV_W{~rd_clr_ov}}) | ev_overflow;
            ev_oc_prev <= ev_hp_overcurrent;
            ev_ov_prev <= ev_overflow;
        end
    end

    // ==========================================================
    // per output trigger and pending terms
    // ==========================================================
    logic [1:0] trig;   // rising edge of an enabled event
    logic [1:0] pend;   // an enabled flag is still unread
    logic [1:0] mode;   // 1 means pulse train
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            trig[c] = (cfg[c][CFG_OC] & ev_hp_overcurrent & ~ev_oc_prev)
                    | (|(cfg[c][CFG_OV_LSB +: OV_W] & ev_overflow & ~ev_ov_prev));
            pend[c] = (cfg[c][CFG_OC] & flag_oc)
                    | (|(cfg[c][CFG_OV_LSB +: OV_W] & flag_ov));
            mode[c] = cfg[c][CFG_MODE];
        end
    end

    // ==========================================================
    // pulse generation
    // ==========================================================
    // the train only runs while pend holds, so reading the flags stops it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            int_q   <= 2'h0;
            pcnt[0] <= '0;
            pcnt[1] <= '0;
            tcnt[0] <= '0;
            tcnt[1] <= '0;
        end
        else if (ce)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (trig[c])
                    pcnt[c] <= CNT_W'(PULSE_CYC);
                else if (pcnt[c] != '0)
                    pcnt[c] <= pcnt[c] - 1'b1;
                if (trig[c] || !pend[c] || tcnt[c] == CNT_W'(TRAIN_CYC - 1))
                    tcnt[c] <= '0;
                else
                    tcnt[c] <= tcnt[c] + 1'b1;
                if (mode[c] == AAI_PULSE_TRAIN)
                    int_q[c] <= pend[c] && (tcnt[c] < CNT_W'(PULSE_CYC));
                else
                    int_q[c] <= trig[c] || (pcnt[c] > CNT_W'(1));
            end
        end
    end
    assign interrupt_out_one = int_q[0];
    assign interrupt_out_two = int_q[1];

    // ==========================================================
    // pin routing and host interrupt
    // ==========================================================
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            gpio_int_out <= 1'b0;
            dout_int_out <= 1'b0;
            miso_int_out <= 1'b0;
            miso_int_sel <= 1'b0;
        end
        else if (ce)
        begin
            gpio_int_out <= aai_route(rt_gpio, int_q);
            dout_int_out <= aai_route(rt_dout, int_q);
            miso_int_out <= aai_route(rt_miso, int_q);
            miso_int_sel <= rt_miso[1:0] != ROUTE_OFF;
        end
    end

    // status bits set by triggers, cleared by writing one; set wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq_status <= 2'h0;
        else if (ce)
        begin
            if (wr_en && wr_dec[7:0] == IDX_IRQ_STAT)
                irq_status <= (irq_status & ~w_data_q[1:0]) | trig;
            else
                irq_status <= irq_status | trig;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst || !ce);

    sequence s_single_trig;
        trig[0] && mode[0] == AAI_ONE_PULSE;
    endsequence
    sequence s_two_cycle_pulse;
        int_q[0] [*2];
    endsequence

    chk_cfg_one_write: assert property (wr_en && wr_dec[7:0] == IDX_CFG_ONE |=> cfg[0] == $past(w_data_q))
        else $error("config write did not land");
    chk_flag_set_event: assert property (ev_hp_overcurrent |=> flag_oc)
        else $error("overcurrent not flagged");
    chk_flag_read_clear: assert property (rd_clr_oc && !ev_hp_overcurrent |=> !flag_oc)
        else $error("flag read did not clear");
    chk_single_pulse_width: assert property (s_single_trig |=> s_two_cycle_pulse)
        else $error("single pulse too short");
    chk_disabled_event: assert property (cfg[1][CFG_OC] == 1'b0 && ev_overflow == ev_ov_prev |-> !trig[1])
        else $error("disabled event triggered");
    chk_train_stops: assert property (mode[1] == AAI_PULSE_TRAIN && !pend[1] |=> !int_q[1])
        else $error("train ran without pending flag");
    chk_train_repeats: assert property (mode[1] == AAI_PULSE_TRAIN && pend[1] && tcnt[1] == '0 |=> int_q[1])
        else $error("train pulse missing");
    chk_gpio_route: assert property (rt_gpio[1:0] == ROUTE_ONE |=> gpio_int_out == $past(int_q[0]))
        else $error("gpio routing wrong");
    // a write of ones clears those status bits unless a trigger lands on them in the same cycle
    chk_status_clear: assert property (wr_en && wr_dec[7:0] == IDX_IRQ_STAT && (w_data_q[1:0] & trig) == 2'h0
                                       |=> (irq_status & $past(w_data_q[1:0])) == 2'h0)
        else $error("status bit not cleared by write");

endmodule : aai_interrupt_logic

// ### rtl/aai_pkg.sv
// package for the amplifier interrupt block: register indices, field layout,
// reset values and timing counts.
// assumes a 25 MHz core clock and 32-bit AXI4-Lite data.
package aai_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_MHZ   = 25;                                    // core clock rate
    localparam int PULSE_NS  = 80;                                    // width of one pulse
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;     // rounded up, 2
    localparam int TRAIN_NS  = 640;                                   // pulse train period
    localparam int TRAIN_CYC = (TRAIN_NS * CLK_MHZ) / 1000;           // rounded down, 16
    localparam int CNT_W     = 8;                                     // counter width

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [7:0] IDX_FLAG_OC  = 8'h2A;   // sticky overcurrent flag, read clears
    localparam logic [7:0] IDX_FLAG_OV  = 8'h2C;   // sticky overflow flags, read clears
    localparam logic [7:0] IDX_CFG_ONE  = 8'h30;   // config of interrupt_out_one
    localparam logic [7:0] IDX_CFG_TWO  = 8'h31;   // config of interrupt_out_two
    localparam logic [7:0] IDX_RT_GPIO  = 8'h34;   // general pin routing
    localparam logic [7:0] IDX_RT_DOUT  = 8'h35;   // data-out pin routing
    localparam logic [7:0] IDX_RT_MISO  = 8'h37;   // spi data-out pin routing
    localparam logic [7:0] IDX_IRQ_STAT = 8'h40;   // interrupt status, write one to clear
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;   // interrupt mask

    // ==========================================================
    // field layout and reset values
    // ==========================================================
    localparam int OV_W       = 3;                 // number of overflow sources
    localparam int CFG_MODE   = 0;                 // 0 single pulse, 1 pulse train
    localparam int CFG_OV_LSB = 4;                 // overflow enables [6:4]
    localparam int CFG_OC     = 7;                 // overcurrent enable
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [1:0] ROUTE_OFF = 2'h0;       // pin not used for an interrupt
    localparam logic [1:0] ROUTE_ONE = 2'h1;       // pin carries interrupt_out_one
    localparam logic [1:0] ROUTE_TWO = 2'h2;       // pin carries interrupt_out_two
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic
    {
        AAI_ONE_PULSE   = 1'b0,
        AAI_PULSE_TRAIN = 1'b1
    } aai_mode_t;

endpackage : aai_pkg
